//--- common/crs_pkg.sv
// Constants and types shared by the core register set
package crs_pkg;

	localparam int unsigned CRS_DATA_W = 8;
	localparam int unsigned CRS_ADDR_W = 16;

	// Condition flag positions and result bit indices
	localparam int unsigned CRS_FLAG_C = 0;
	localparam int unsigned CRS_FLAG_Z = 1;
	localparam int unsigned CRS_FLAG_N = 2;
	localparam int unsigned CRS_FLAG_I = 3;
	localparam int unsigned CRS_FLAG_H = 4;
	localparam int unsigned CRS_MSB    = 7;
	localparam int unsigned CRS_HALF   = 4;

	// Reset values, fixed bits, stack base and sequencer step limits
	localparam logic [7:0]  CRS_FLAGS_RST   = 8'hE8;
	localparam logic [7:0]  CRS_FLAGS_FIXED = 8'hE0;
	localparam logic [15:0] CRS_SP_RST      = 16'h017F;
	localparam logic [15:0] CRS_SP_BASE     = 16'h0100;
	localparam int unsigned CRS_SP_LOW_W    = 7;
	localparam logic [7:0]  CRS_ZERO8       = 8'h00;
	localparam logic [15:0] CRS_ZERO16      = 16'h0000;
	localparam logic [2:0]  CRS_CTX_LAST    = 3'h4;
	localparam logic [2:0]  CRS_CALL_LAST   = 3'h1;

	// Register selector for dedicated move instructions
	typedef enum logic [2:0] {
		CRS_SEL_ACC,
		CRS_SEL_IDX_X,
		CRS_SEL_IDX_Y,
		CRS_SEL_FLAGS,
		CRS_SEL_SP_LOW,
		CRS_SEL_PC_LOW,
		CRS_SEL_PC_HIGH
	} crs_sel_t;

	// Operations requested by the execution unit
	typedef enum logic [3:0] {
		CRS_OP_NONE,
		CRS_OP_ADD,
		CRS_OP_ADC,
		CRS_OP_SUB,
		CRS_OP_LOGIC,
		CRS_OP_MOVE,
		CRS_OP_SHIFT,
		CRS_OP_SET_CARRY,
		CRS_OP_CLEAR_CARRY,
		CRS_OP_MASK_INT,
		CRS_OP_UNMASK_INT,
		CRS_OP_STACK_REINIT,
		CRS_OP_PUSH,
		CRS_OP_POP
	} crs_op_t;

	// Stack sequencer modes
	typedef enum logic [2:0] {
		CRS_SEQ_IDLE,
		CRS_SEQ_INT_PUSH,
		CRS_SEQ_INT_POP,
		CRS_SEQ_CALL_PUSH,
		CRS_SEQ_RET_POP
	} crs_seq_t;

	// Instruction request from the executing core
	typedef struct packed {
		crs_op_t   op;
		crs_sel_t  dst;
		logic      wr_en;
		logic [7:0] operand_a;
		logic [7:0] operand_b;
		logic [7:0] result;
		logic      carry_out;
		logic      shift_carry;
		logic      pc_load;
		logic [15:0] pc_value;
		logic      pc_step;
	} crs_req_t;

	// Stack memory port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crs_mem_t;

endpackage

//--- dv/crs_core_regs_sva.sv
// Port assertions for the core register set
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs_sva
	import crs_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire crs_req_t    req,
	input wire logic        int_request,
	input wire logic        trap_request,
	input wire logic        interrupt_return_instr,
	input wire logic        call_start,
	input wire logic        ret_start,
	input wire logic [7:0]  condition_flags,
	input wire logic [15:0] stack_pointer,
	input wire logic        int_take,
	input wire logic        int_pending,
	input wire logic        seq_busy,
	input wire crs_mem_t    mem
);
	logic plain;
	assign plain = !seq_busy && !trap_request && !int_request && !int_pending
		&& !interrupt_return_instr && !call_start && !ret_start;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sp_upper_a: assert property (stack_pointer[15:7] == 9'h002)
		else $error("stack pointer upper bits moved");
	flags_fixed_a: assert property (condition_flags[7:5] == 3'h7)
		else $error("fixed flag bits not one");
	trap_take_a: assert property (trap_request && !seq_busy |=> int_take)
		else $error("trap not taken");
	ctx_push_a: assert property (int_take |=> mem.wr [*5])
		else $error("context push not five bytes");
	push_step_a: assert property (mem.wr ##1 mem.wr |->
		mem.addr[6:0] == $past(mem.addr[6:0]) - 7'h01) else $error("push address step wrong");
	mask_block_a: assert property (condition_flags[3] && !trap_request |=> !int_take)
		else $error("masked request taken");
	pend_latch_a: assert property (int_request && condition_flags[3] |=> int_pending)
		else $error("masked request not held");
	interrupt_return_instr_unmask_a: assert property (interrupt_return_instr && !seq_busy &&
		condition_flags[3] && !trap_request |-> ##[1:8] !condition_flags[3])
		else $error("return left mask set");
	reinit_a: assert property (plain && req.op == CRS_OP_STACK_REINIT |=>
		stack_pointer == 16'h017F) else $error("stack reinit wrong");
	move_flags_a: assert property (plain && req.op == CRS_OP_MOVE &&
		!(req.wr_en && req.dst == CRS_SEL_FLAGS) |=> condition_flags[2:1] ==
		{$past(req.result[7]), $past(req.result) == 8'h00}) else $error("move flags wrong");
	carry_a: assert property (plain && req.op == CRS_OP_SET_CARRY |=> condition_flags[0])
		else $error("carry not set");
	cover property (int_take);
	cover property (interrupt_return_instr && !seq_busy);
	cover property (mem.wr ##1 mem.wr);
endmodule
bind crs_core_regs crs_core_regs_sva crs_core_regs_sva_i (.clock(clock), .sys_rst(sys_rst),
	.req(req), .int_request(int_request), .trap_request(trap_request),
	.interrupt_return_instr(interrupt_return_instr), .call_start(call_start),
	.ret_start(ret_start), .condition_flags(condition_flags),
	.stack_pointer(stack_pointer), .int_take(int_take), .int_pending(int_pending),
	.seq_busy(seq_busy), .mem(mem));
`default_nettype wire

//--- dv/tb_crs_core_regs.sv
// Self-checking bench for the core register set
`timescale 1ns/100ps
`default_nettype none
module tb_crs_core_regs
	import crs_pkg::*;
;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	crs_req_t    req = '0;
	logic        int_request = 1'b0;
	logic        trap_request = 1'b0;
	logic        int_ack = 1'b0;
	logic        interrupt_return_instr = 1'b0;
	logic        call_start = 1'b0;
	logic        ret_start = 1'b0;
	logic [7:0]  mem_rdata = 8'h00;
	logic [7:0]  rd_data, accumulator, index_x, index_y, condition_flags;
	logic [15:0] program_counter, stack_pointer;
	logic        int_take, int_pending, seq_busy;
	crs_mem_t    mem;
	int          n_fail = 0;
	int          n_checks = 0;
	logic [7:0]  stk [0:127];
	logic [15:0] wa [$];
	logic [7:0]  wd [$];
	logic [7:0]  f;
	crs_core_regs crs_core_regs_i (.clock(clock), .sys_rst(sys_rst), .req(req),
		.int_request(int_request), .trap_request(trap_request), .int_ack(int_ack),
		.interrupt_return_instr(interrupt_return_instr), .call_start(call_start),
		.ret_start(ret_start), .mem_rdata(mem_rdata), .rd_data(rd_data),
		.accumulator(accumulator), .index_x(index_x), .index_y(index_y),
		.program_counter(program_counter), .condition_flags(condition_flags),
		.stack_pointer(stack_pointer), .int_take(int_take), .int_pending(int_pending),
		.seq_busy(seq_busy), .mem(mem));
	always #50 clock = ~clock;
	// Stack memory, read data ready one cycle after the strobe
	always @(negedge clock) begin
		if (mem.wr === 1'b1) begin
			stk[mem.addr[6:0]] <= mem.wdata;
			wa.push_back(mem.addr);
			wd.push_back(mem.wdata);
		end
		mem_rdata <= stk[mem.addr[6:0]];
	end
	task automatic ck(input logic ok, input int id);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("mismatch at %0t: check %0d", $time, id);
		end
	endtask
	task automatic op(input crs_op_t o, input crs_sel_t d, input logic [7:0] a, b, r,
		input logic c);
		req.op = o;
		req.dst = d;
		req.wr_en = (o != CRS_OP_NONE);
		req.operand_a = a;
		req.operand_b = b;
		req.result = r;
		req.carry_out = c;
		req.shift_carry = c;
		@(negedge clock);
		req = '0;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	task automatic settle();
		for (int i = 0; i < 40 && seq_busy !== 1'b0; i++) @(negedge clock);
		@(negedge clock);
		ck(seq_busy === 1'b0, 1);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic t_reset();
		ck(condition_flags === 8'hE8, 2);
		ck(stack_pointer === 16'h017F, 3);
	endtask
	task automatic t_flags();
		op(CRS_OP_ADD, CRS_SEL_ACC, 8'h08, 8'h08, 8'h10, 1'b0);
		ck(condition_flags[4] === 1'b1 && accumulator === 8'h10, 10);
		op(CRS_OP_ADD, CRS_SEL_ACC, 8'h01, 8'h02, 8'h03, 1'b0);
		ck(condition_flags[4] === 1'b0, 11);
		op(CRS_OP_ADD, CRS_SEL_ACC, 8'hF0, 8'h10, 8'h00, 1'b1);
		ck(condition_flags[2:0] === 3'h3, 12);
		op(CRS_OP_LOGIC, CRS_SEL_ACC, 8'h00, 8'h00, 8'h80, 1'b0);
		ck(condition_flags[2:1] === 2'h2, 13);
		op(CRS_OP_CLEAR_CARRY, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(condition_flags[0] === 1'b0, 14);
		op(CRS_OP_ADC, CRS_SEL_ACC, 8'h08, 8'h08, 8'h10, 1'b0);
		ck(condition_flags[4] === 1'b1, 15);
		op(CRS_OP_SHIFT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h01, 1'b1);
		ck(condition_flags[0] === 1'b1, 16);
		op(CRS_OP_SUB, CRS_SEL_ACC, 8'h00, 8'h01, 8'hFF, 1'b0);
		ck(condition_flags[0] === 1'b0, 17);
		op(CRS_OP_SET_CARRY, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(condition_flags[0] === 1'b1, 18);
		op(CRS_OP_UNMASK_INT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(condition_flags[3] === 1'b0, 19);
		op(CRS_OP_MASK_INT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(condition_flags[3] === 1'b1, 20);
	endtask
	task automatic t_context();
		op(CRS_OP_MOVE, CRS_SEL_ACC, 8'h00, 8'h00, 8'h5A, 1'b0);
		op(CRS_OP_MOVE, CRS_SEL_IDX_X, 8'h00, 8'h00, 8'hC3, 1'b0);
		op(CRS_OP_MOVE, CRS_SEL_IDX_Y, 8'h00, 8'h00, 8'h77, 1'b0);
		req.pc_load = 1'b1;
		req.pc_value = 16'h1234;
		op(CRS_OP_NONE, CRS_SEL_IDX_X, 8'h00, 8'h00, 8'h00, 1'b0);
		op(CRS_OP_NONE, CRS_SEL_IDX_X, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(program_counter === 16'h1234 && rd_data === 8'hC3, 30);
		ck(accumulator === 8'h5A && index_y === 8'h77, 31);
		f = condition_flags;
		wa.delete();
		wd.delete();
		pulse(trap_request);
		settle();
		ck(wa.size() == 5 && stack_pointer === 16'h017A, 32);
		for (int i = 0; i < 5 && i < wa.size(); i++) begin
			ck(wa[i] === 16'h017F - 16'(i), 33);
		end
		ck(wd[0] === 8'h34 && wd[1] === 8'h12 && wd[2] === 8'hC3, 34);
		ck(wd[3] === 8'h5A && wd[4] === f && condition_flags[3] === 1'b1, 35);
		op(CRS_OP_MOVE, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		op(CRS_OP_MOVE, CRS_SEL_IDX_X, 8'h00, 8'h00, 8'h00, 1'b0);
		pulse(interrupt_return_instr);
		settle();
		ck(stack_pointer === 16'h017F && program_counter === 16'h1234, 36);
		ck(accumulator === 8'h5A && index_x === 8'hC3 && index_y === 8'h77, 37);
		ck(condition_flags === (f & 8'hF7), 38);
	endtask
	task automatic t_pending();
		logic seen;
		seen = 1'b0;
		op(CRS_OP_MASK_INT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		pulse(int_request);
		repeat (3) @(negedge clock);
		ck(int_pending === 1'b1 && int_take === 1'b0, 40);
		op(CRS_OP_UNMASK_INT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		repeat (4) begin
			@(negedge clock);
			seen = seen | (int_take === 1'b1);
		end
		ck(seen, 41);
		pulse(int_ack);
		settle();
		ck(condition_flags[3] === 1'b1 && stack_pointer === 16'h017A, 42);
		ck(int_pending === 1'b0, 43);
		pulse(interrupt_return_instr);
		settle();
		ck(condition_flags[3] === 1'b0 && stack_pointer === 16'h017F, 44);
	endtask
	task automatic t_stack();
		op(CRS_OP_PUSH, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h017E, 50);
		op(CRS_OP_POP, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h017F, 51);
		op(CRS_OP_MOVE, CRS_SEL_SP_LOW, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h0100, 52);
		op(CRS_OP_PUSH, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h017F, 53);
		op(CRS_OP_POP, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h0100, 54);
		op(CRS_OP_MOVE, CRS_SEL_SP_LOW, 8'h00, 8'h00, 8'hC5, 1'b0);
		ck(stack_pointer === 16'h0145, 55);
		op(CRS_OP_STACK_REINIT, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(stack_pointer === 16'h017F, 56);
	endtask
	task automatic t_call();
		wa.delete();
		wd.delete();
		pulse(call_start);
		settle();
		ck(wa.size() == 2 && stack_pointer === 16'h017D, 60);
		ck(wa[0] === 16'h017F && wd[0] === 8'h34 && wd[1] === 8'h12, 61);
		req.pc_load = 1'b1;
		req.pc_value = 16'h0000;
		op(CRS_OP_NONE, CRS_SEL_ACC, 8'h00, 8'h00, 8'h00, 1'b0);
		pulse(ret_start);
		settle();
		ck(stack_pointer === 16'h017F && program_counter === 16'h1234, 62);
		req.pc_step = 1'b1;
		op(CRS_OP_NONE, CRS_SEL_PC_HIGH, 8'h00, 8'h00, 8'h00, 1'b0);
		ck(program_counter === 16'h1235 && rd_data === 8'h12, 63);
	endtask
	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		t_reset();
		t_flags();
		t_context();
		t_pending();
		t_stack();
		t_call();
		conclude();
	end
endmodule
`default_nettype wire

//--- verilog/crs_core_regs.sv
// Programmer-visible register set of the 8-bit core
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE1 - 8-bit accumulator holds operands and results
// RULE2 - two 8-bit index registers
// RULE3 - second index never saved on interrupts
// RULE4 - 16-bit program counter, low and high bytes
// RULE5 - registers reached only by dedicated instructions
// RULE6 - flags reset with upper bits and mask set
// RULE7 - half carry from bit 3 on add
// RULE8 - mask set on entry or software
// RULE9 - masked requests held pending until unmasked
// RULE10 - interrupt return clears mask, pending then taken
// RULE11 - negative copies result bit 7
// RULE12 - zero set when result is zero
// RULE13 - carry from arithmetic, set/clear, shifts, bit tests (no bit-test op here; carry comes from ADD, ADC, SUB, SHIFT, SET/CLEAR)
// RULE14 - stack pointer upper nine bits fixed
// RULE15 - stack pointer reset and reinit to top
// RULE16 - decrement after push, increment before pop
// RULE17 - stack pointer wraps silently both ways
// RULE18 - stack pointer low byte loadable
// RULE19 - interrupt pushes program counter low first
// RULE20 - call uses two bytes, interrupt five
// RULE21 - context order PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, flags
module crs_core_regs
	import crs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire crs_req_t    req,
	input  wire logic        int_request,
	input  wire logic        trap_request,
	input  wire logic        int_ack,
	input  wire logic        interrupt_return_instr,
	input  wire logic        call_start,
	input  wire logic        ret_start,
	input  wire logic [7:0]  mem_rdata,
	output var  logic [7:0]  rd_data,
	output var  logic [7:0]  accumulator,
	output var  logic [7:0]  index_x,
	output var  logic [7:0]  index_y,
	output var  logic [15:0] program_counter,
	output var  logic [7:0]  condition_flags,
	output var  logic [15:0] stack_pointer,
	output var  logic        int_take,
	output var  logic        int_pending,
	output var  logic        seq_busy,
	output var  crs_mem_t    mem
);
	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idx_x;
		logic [7:0]  idx_y;
		logic [15:0] pc;
		logic [7:0]  flags;
		logic        pending;
		logic        take;
		logic        busy;
		logic        pop_seq;
		crs_seq_t    seq;
		logic [2:0]  step;
		logic [7:0]  rd;
		crs_mem_t    mem;
	} crs_state_t;

	crs_state_t state_r;
	crs_state_t state_nxt;

	logic [15:0] sp;
	logic [15:0] sp_pre_inc;
	logic        sp_push;
	logic        sp_pop;
	logic        sp_load;
	logic        sp_reinit;
	logic [4:0]  half_sum;

	// Byte pushed at each step of the interrupt context
	function automatic logic [7:0] ctx_byte(input logic [2:0] step, input crs_state_t s);
		logic [7:0] b;
		b = s.flags;
		case (step)
			3'h0: b = s.pc[7:0]; // see RULE19
			3'h1: b = s.pc[15:8]; // see RULE21
			3'h2: b = s.idx_x; // see RULE21
			3'h3: b = s.acc; // see RULE21
			default: b = s.flags; // see RULE21
		endcase
		return b;
	endfunction

	// Flag update from a result byte
	function automatic logic [7:0] nz_update(input logic [7:0] f, input logic [7:0] res);
		logic [7:0] o;
		o = f;
		o[CRS_FLAG_N] = res[CRS_MSB]; // see RULE11
		o[CRS_FLAG_Z] = (res == CRS_ZERO8); // see RULE12
		return o;
	endfunction

	crs_stack_ptr #(
		.LOW_W(CRS_SP_LOW_W)
	) u_sp (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.reinit     (sp_reinit),
		.push       (sp_push),
		.pop        (sp_pop),
		.load       (sp_load),
		.load_value (req.result),
		.sp         (sp),
		.sp_pre_inc (sp_pre_inc)
	);

	always_comb begin
		state_nxt = state_r;
		sp_push = 1'b0;
		sp_pop = 1'b0;
		sp_load = 1'b0;
		sp_reinit = 1'b0;
		half_sum = {1'b0, req.operand_a[3:0]} + {1'b0, req.operand_b[3:0]} +
			{4'h0, (req.op == CRS_OP_ADC) ? state_r.flags[CRS_FLAG_C] : 1'b0};
		state_nxt.mem.wr = 1'b0;
		state_nxt.mem.rd = 1'b0;
		state_nxt.take = 1'b0;
		state_nxt.pop_seq = 1'b0;

		// Pending latch; set wins over acknowledge
		if (int_request) begin
			state_nxt.pending = 1'b1; // see RULE9
		end else if (int_ack) begin
			state_nxt.pending = 1'b0;
		end

		if (req.pc_load) begin
			state_nxt.pc = req.pc_value; // see RULE4
		end else if (req.pc_step) begin
			state_nxt.pc = state_r.pc + 16'h0001;
		end

		case (state_r.seq)
			CRS_SEQ_IDLE: begin
				if (trap_request || ((int_request || state_r.pending) &&
						!state_r.flags[CRS_FLAG_I])) begin
					state_nxt.take = 1'b1; // see RULE8
					state_nxt.seq = CRS_SEQ_INT_PUSH;
					state_nxt.step = 3'h0;
				end else if (interrupt_return_instr) begin
					state_nxt.seq = CRS_SEQ_INT_POP;
					state_nxt.step = CRS_CTX_LAST;
				end else if (call_start) begin
					state_nxt.seq = CRS_SEQ_CALL_PUSH;
					state_nxt.step = 3'h0;
				end else if (ret_start) begin
					state_nxt.seq = CRS_SEQ_RET_POP;
					state_nxt.step = CRS_CALL_LAST;
				end else begin
					if (req.wr_en && req.op == CRS_OP_MOVE) begin
						case (req.dst)
							CRS_SEL_ACC:     state_nxt.acc = req.result; // see RULE1
							CRS_SEL_IDX_X:   state_nxt.idx_x = req.result; // see RULE2
							CRS_SEL_IDX_Y:   state_nxt.idx_y = req.result; // see RULE2
							CRS_SEL_FLAGS:   state_nxt.flags = req.result | CRS_FLAGS_FIXED;
							CRS_SEL_SP_LOW:  sp_load = 1'b1; // see RULE18
							CRS_SEL_PC_LOW:  state_nxt.pc[7:0] = req.result;
							CRS_SEL_PC_HIGH: state_nxt.pc[15:8] = req.result;
							default:         state_nxt.acc = state_r.acc;
						endcase
						if (req.dst != CRS_SEL_FLAGS) begin // see RULE11 RULE12
							state_nxt.flags = nz_update(state_r.flags, req.result);
						end
					end else if (req.wr_en) begin
						case (req.dst)
							CRS_SEL_IDX_X: state_nxt.idx_x = req.result;
							CRS_SEL_IDX_Y: state_nxt.idx_y = req.result;
							default:       state_nxt.acc = req.result; // see RULE1
						endcase
					end
					case (req.op)
						CRS_OP_ADD, CRS_OP_ADC: begin
							state_nxt.flags = nz_update(state_r.flags, req.result);
							state_nxt.flags[CRS_FLAG_H] = half_sum[CRS_HALF]; // see RULE7
							state_nxt.flags[CRS_FLAG_C] = req.carry_out; // see RULE13
						end
						CRS_OP_SUB: begin
							state_nxt.flags = nz_update(state_r.flags, req.result);
							state_nxt.flags[CRS_FLAG_C] = req.carry_out; // see RULE13
						end
						CRS_OP_LOGIC: state_nxt.flags = nz_update(state_r.flags, req.result);
						CRS_OP_SHIFT: begin
							state_nxt.flags = nz_update(state_r.flags, req.result);
							state_nxt.flags[CRS_FLAG_C] = req.shift_carry; // see RULE13
						end
						CRS_OP_SET_CARRY:   state_nxt.flags[CRS_FLAG_C] = 1'b1; // see RULE13
						CRS_OP_CLEAR_CARRY: state_nxt.flags[CRS_FLAG_C] = 1'b0; // see RULE13
						CRS_OP_MASK_INT:    state_nxt.flags[CRS_FLAG_I] = 1'b1; // see RULE8
						CRS_OP_UNMASK_INT:  state_nxt.flags[CRS_FLAG_I] = 1'b0; // see RULE10
						CRS_OP_STACK_REINIT: sp_reinit = 1'b1; // see RULE15
						CRS_OP_PUSH: begin
							state_nxt.mem.wr = 1'b1;
							state_nxt.mem.addr = sp;
							state_nxt.mem.wdata = req.result;
							sp_push = 1'b1; // see RULE16
						end
						CRS_OP_POP: begin
							state_nxt.mem.rd = 1'b1;
							state_nxt.mem.addr = sp_pre_inc; // see RULE16
							sp_pop = 1'b1;
						end
						default: state_nxt.flags = state_nxt.flags;
					endcase
				end
			end
			CRS_SEQ_INT_PUSH, CRS_SEQ_CALL_PUSH: begin
				state_nxt.mem.wr = 1'b1;
				state_nxt.mem.addr = sp; // see RULE19
				state_nxt.mem.wdata = ctx_byte(state_r.step, state_r);
				sp_push = 1'b1;
				state_nxt.step = state_r.step + 3'h1;
				if (state_r.seq == CRS_SEQ_CALL_PUSH && state_r.step == CRS_CALL_LAST) begin
					state_nxt.seq = CRS_SEQ_IDLE; // see RULE20
				end else if (state_r.step == CRS_CTX_LAST) begin
					state_nxt.seq = CRS_SEQ_IDLE; // see RULE20
					state_nxt.flags[CRS_FLAG_I] = 1'b1; // see RULE8
				end
			end
			CRS_SEQ_INT_POP, CRS_SEQ_RET_POP: begin
				// Reads issued; data arrives next cycle at previous step
				state_nxt.mem.rd = 1'b1;
				state_nxt.mem.addr = sp_pre_inc;
				state_nxt.pop_seq = 1'b1;
				sp_pop = 1'b1;
				state_nxt.step = state_r.step - 3'h1;
				if (state_r.step == 3'h0) begin
					state_nxt.seq = CRS_SEQ_IDLE;
				end
			end
			default: state_nxt.seq = CRS_SEQ_IDLE;
		endcase

		// Popped byte lands one cycle after its read; index Y untouched
		if (state_r.mem.rd && state_r.pop_seq) begin // see RULE3
			case (state_r.step + ((state_r.seq == CRS_SEQ_IDLE) ? 3'h0 : 3'h1))
				CRS_CTX_LAST: begin
					state_nxt.flags = mem_rdata | CRS_FLAGS_FIXED; // see RULE21
					state_nxt.flags[CRS_FLAG_I] = 1'b0; // see RULE10
				end
				3'h3: state_nxt.acc = mem_rdata;
				3'h2: state_nxt.idx_x = mem_rdata;
				3'h1: state_nxt.pc[15:8] = mem_rdata;
				default: state_nxt.pc[7:0] = mem_rdata;
			endcase
		end
		if (interrupt_return_instr && state_r.seq == CRS_SEQ_IDLE) begin
			state_nxt.flags[CRS_FLAG_I] = 1'b0; // see RULE10
		end

		case (req.dst)
			CRS_SEL_ACC:     state_nxt.rd = state_r.acc; // see RULE5
			CRS_SEL_IDX_X:   state_nxt.rd = state_r.idx_x;
			CRS_SEL_IDX_Y:   state_nxt.rd = state_r.idx_y;
			CRS_SEL_FLAGS:   state_nxt.rd = state_r.flags;
			CRS_SEL_SP_LOW:  state_nxt.rd = sp[7:0]; // see RULE18
			CRS_SEL_PC_LOW:  state_nxt.rd = state_r.pc[7:0];
			default:         state_nxt.rd = state_r.pc[15:8];
		endcase
		state_nxt.busy = (state_nxt.seq != CRS_SEQ_IDLE);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r.acc <= CRS_ZERO8;
			state_r.idx_x <= CRS_ZERO8;
			state_r.idx_y <= CRS_ZERO8;
			state_r.pc <= CRS_ZERO16;
			state_r.flags <= CRS_FLAGS_RST; // see RULE6
			state_r.pending <= 1'b0;
			state_r.take <= 1'b0;
			state_r.busy <= 1'b0;
			state_r.pop_seq <= 1'b0;
			state_r.seq <= CRS_SEQ_IDLE;
			state_r.step <= 3'h0;
			state_r.rd <= CRS_ZERO8;
			state_r.mem <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rd_data = state_r.rd;
	assign accumulator = state_r.acc;
	assign index_x = state_r.idx_x;
	assign index_y = state_r.idx_y;
	assign program_counter = state_r.pc;
	assign condition_flags = state_r.flags;
	assign stack_pointer = sp;
	assign int_take = state_r.take;
	assign int_pending = state_r.pending;
	assign seq_busy = state_r.busy;
	assign mem = state_r.mem;
endmodule
`default_nettype wire

//--- verilog/crs_stack_ptr.sv
// Stack pointer with fixed upper bits and low seven-bit wrap
`timescale 1ns/100ps
`default_nettype none
module crs_stack_ptr
	import crs_pkg::*;
#(
	parameter int unsigned LOW_W = CRS_SP_LOW_W
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        reinit,
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic        load,
	input  wire logic [7:0]  load_value,
	output var  logic [15:0] sp,
	output var  logic [15:0] sp_pre_inc
);
	typedef struct packed {
		logic [LOW_W-1:0] low;
	} crs_sp_state_t;

	crs_sp_state_t state_r;
	crs_sp_state_t state_nxt;
	logic [LOW_W-1:0] inc_low;

	always_comb begin
		inc_low = state_r.low + 1'b1; // see RULE17
		state_nxt = state_r;
		if (reinit) begin
			state_nxt.low = CRS_SP_RST[LOW_W-1:0]; // see RULE15
		end else if (load) begin
			state_nxt.low = load_value[LOW_W-1:0]; // see RULE18
		end else if (push) begin
			state_nxt.low = state_r.low - 1'b1; // see RULE16
		end else if (pop) begin
			state_nxt.low = inc_low; // see RULE16
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r.low <= CRS_SP_RST[LOW_W-1:0]; // see RULE15
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sp = {CRS_SP_BASE[15:LOW_W], state_r.low}; // see RULE14
	assign sp_pre_inc = {CRS_SP_BASE[15:LOW_W], inc_low};
endmodule
`default_nettype wire
